// [verilog/bwrl_watchdog.sv]
`timescale 1ns/1ns
// Notes on behaviour
// - Timeout after 1420 ms without retrigger
// - Active hold 200 ms, then self release
// - Enable setting gates watchdog onto reset
// - Release restarts processor at address zero
// - Any reset source asserts system reset
// - Closed manual contact asserts reset
// - Reset also driven to expansion connector
// - Indicator lamp on while watchdog active
module bwrl_watchdog
    import bwrl_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = CYCLES_PER_TICK,
    parameter int unsigned TIMEOUT_T   = TIMEOUT_MS,
    parameter int unsigned HOLD_T      = HOLD_MS
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        retrigger,
    input  wire logic        watchdog_link_setting,
    input  wire logic        power_good,
    input  wire logic        manual_reset_contact,
    output logic             sys_reset_n,
    output logic             expansion_bus_connector_reset_n,
    output logic             watchdog_indicator_lamp,
    output logic [15:0]      boot_vector
);
    // ************************************************
    // Helpers
    // ************************************************
    // True on the last count of an interval; shared by the counter and its checks
    function automatic logic last_count(logic [MS_W-1:0] cnt, int unsigned span);
        return cnt == MS_W'(span - 1);
    endfunction

    // ************************************************
    // Time base
    // ************************************************
    logic [TICK_W-1:0] pre_q, pre_d;
    logic              tick;

    always_comb begin
        tick  = (pre_q == TICK_W'(TICK_CYCLES - 1));
        pre_d = tick ? '0 : pre_q + 1'b1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_d;
        end
    end

    // ************************************************
    // Watchdog
    // ************************************************
    bwrl_state_t       st_q, st_d;
    logic [MS_W-1:0]   ms_q, ms_d;
    logic              ext_rst;

    // Board reset from outside sources restarts the watch interval too
    assign ext_rst = !power_good || manual_reset_contact;

    always_comb begin
        st_d = st_q;
        ms_d = ms_q;
        case (st_q)
            BWRL_WATCH: begin
                if (retrigger || ext_rst) begin
                    ms_d = '0;
                end else if (tick) begin
                    if (last_count(ms_q, TIMEOUT_T)) begin
                        st_d = BWRL_HOLD;
                        ms_d = '0;
                    end else begin
                        ms_d = ms_q + 1'b1;
                    end
                end
            end
            BWRL_HOLD: begin
                // Retrigger is ignored here: with the link setting on, the controller is held in reset anyway
                if (tick) begin
                    if (last_count(ms_q, HOLD_T)) begin
                        st_d = BWRL_WATCH;
                        ms_d = '0;
                    end else begin
                        ms_d = ms_q + 1'b1;
                    end
                end
            end
            default: begin
                st_d = BWRL_WATCH;
                ms_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= BWRL_WATCH;
            ms_q <= '0;
        end else begin
            st_q <= st_d;
            ms_q <= ms_d;
        end
    end

    // ************************************************
    // Reset outputs
    // ************************************************
    logic rst_q, rst_d;
    logic lamp_q, lamp_d;

    always_comb begin
        rst_d  = ext_rst || ((st_q == BWRL_HOLD) && watchdog_link_setting);
        lamp_d = (st_q == BWRL_HOLD);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rst_q  <= 1'b1;
            lamp_q <= 1'b0;
        end else begin
            rst_q  <= rst_d;
            lamp_q <= lamp_d;
        end
    end

    assign sys_reset_n                     = !rst_q;
    assign expansion_bus_connector_reset_n = !rst_q;
    assign watchdog_indicator_lamp         = lamp_q;
    assign boot_vector                     = BOOT_ADDR;

    // ************************************************
    // Checks
    // ************************************************
    a_src_reset: assert property (@(posedge clk) disable iff (rst)
        ext_rst |=> !sys_reset_n)
        else $error("external source did not assert reset");
    a_gate_off: assert property (@(posedge clk) disable iff (rst)
        (!rst && !ext_rst && !watchdog_link_setting) |=> sys_reset_n)
        else $error("disabled watchdog drove reset");
    a_gate_on: assert property (@(posedge clk) disable iff (rst)
        (st_q == BWRL_HOLD && watchdog_link_setting) |=> !sys_reset_n)
        else $error("enabled watchdog did not drive reset");
    a_exp_match: assert property (@(posedge clk) disable iff (rst)
        expansion_bus_connector_reset_n == sys_reset_n)
        else $error("expansion reset differs");
    a_lamp_hold: assert property (@(posedge clk) disable iff (rst)
        $rose(st_q == BWRL_HOLD) |=> watchdog_indicator_lamp)
        else $error("lamp not lit");
    a_retrig_clr: assert property (@(posedge clk) disable iff (rst)
        (st_q == BWRL_WATCH && retrigger) |=> (ms_q == '0 && st_q == BWRL_WATCH))
        else $error("retrigger did not restart count");
    a_expire: assert property (@(posedge clk) disable iff (rst)
        (st_q == BWRL_WATCH && !retrigger && !ext_rst && tick && last_count(ms_q, TIMEOUT_T))
        |=> st_q == BWRL_HOLD)
        else $error("timeout missed");
    a_release: assert property (@(posedge clk) disable iff (rst)
        (st_q == BWRL_HOLD && tick && last_count(ms_q, HOLD_T)) |=> st_q == BWRL_WATCH)
        else $error("hold did not end");
    a_tick_base: assert property (@(posedge clk) disable iff (rst)
        tick |=> !tick)
        else $error("time base tick too wide");
    a_boot_zero: assert property (@(posedge clk) disable iff (rst)
        $rose(sys_reset_n) |-> boot_vector == BOOT_ADDR)
        else $error("boot vector not zero");

    // ************************************************
    // Checks on the counters
    // ************************************************
    // Reset must leave the watch interval at its start, or the first timeout comes early
    a_reset_idle: assert property (@(posedge clk)
        rst |=> (st_q == BWRL_WATCH && ms_q == '0 && !sys_reset_n && !watchdog_indicator_lamp))
        else $error("reset did not clear the watchdog");
    a_ext_restart: assert property (@(posedge clk) disable iff (rst)
        (st_q == BWRL_WATCH && ext_rst) |=> ms_q == '0)
        else $error("external reset did not restart count");
    a_ms_bound: assert property (@(posedge clk) disable iff (rst)
        (st_q == BWRL_WATCH) |-> ms_q <= MS_W'(TIMEOUT_T - 1))
        else $error("watch count past its end");
    a_hold_bound: assert property (@(posedge clk) disable iff (rst)
        (st_q == BWRL_HOLD) |-> ms_q <= MS_W'(HOLD_T - 1))
        else $error("hold count past its end");
    a_hold_still: assert property (@(posedge clk) disable iff (rst)
        (st_q == BWRL_HOLD && !tick) |=> (st_q == BWRL_HOLD && $stable(ms_q)))
        else $error("hold count moved without a tick");
    a_hold_step: assert property (@(posedge clk) disable iff (rst)
        (st_q == BWRL_HOLD && tick && !last_count(ms_q, HOLD_T))
        |=> (st_q == BWRL_HOLD && ms_q == $past(ms_q) + 1'b1))
        else $error("hold count did not advance");
    a_watch_still: assert property (@(posedge clk) disable iff (rst)
        (st_q == BWRL_WATCH && !retrigger && !ext_rst && !tick)
        |=> (st_q == BWRL_WATCH && $stable(ms_q)))
        else $error("watch count moved without a tick");
    a_watch_step: assert property (@(posedge clk) disable iff (rst)
        (st_q == BWRL_WATCH && !retrigger && !ext_rst && tick && !last_count(ms_q, TIMEOUT_T))
        |=> (st_q == BWRL_WATCH && ms_q == $past(ms_q) + 1'b1))
        else $error("watch count did not advance");
    a_pre_bound: assert property (@(posedge clk) disable iff (rst)
        pre_q <= TICK_W'(TICK_CYCLES - 1))
        else $error("time base past its period");

    // ************************************************
    // Checks on the outputs
    // ************************************************
    // Sampled rst in the antecedent keeps this quiet on the edge that ends reset
    a_release_out: assert property (@(posedge clk) disable iff (rst)
        (!rst && !ext_rst && st_q == BWRL_WATCH) |=> sys_reset_n)
        else $error("reset held with no source");
    a_pfail_reset: assert property (@(posedge clk) disable iff (rst)
        !power_good |=> !sys_reset_n)
        else $error("power fail did not assert reset");
    a_button_reset: assert property (@(posedge clk) disable iff (rst)
        manual_reset_contact |=> !sys_reset_n)
        else $error("closed contact did not assert reset");
    a_lamp_on: assert property (@(posedge clk) disable iff (rst)
        (st_q == BWRL_HOLD) |=> watchdog_indicator_lamp)
        else $error("lamp dark while watchdog active");
    a_lamp_off: assert property (@(posedge clk) disable iff (rst)
        (st_q == BWRL_WATCH) |=> !watchdog_indicator_lamp)
        else $error("lamp lit while watchdog idle");
endmodule

// [verilog/bwrl_pkg.sv]
package bwrl_pkg;
    // ************************************************
    // Timing
    // ************************************************
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned TIMEOUT_MS      = 1420;
    localparam int unsigned HOLD_MS         = 200;
    localparam int unsigned TICK_US         = 1000;
    localparam int unsigned CYCLES_PER_TICK = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned TICK_W          = 16;
    localparam int unsigned MS_W            = 12;
    // ************************************************
    // Boot
    // ************************************************
    localparam logic [15:0] BOOT_ADDR       = 16'h0000;
    // ************************************************
    // States
    // ************************************************
    typedef enum logic [0:0] {
        BWRL_WATCH = 1'b0,
        BWRL_HOLD  = 1'b1
    } bwrl_state_t;
endpackage

// [tb/bwrl_mcu_model.sv]
`timescale 1ns/1ns
// ****************************************
// Controller retrigger model
// ****************************************
module bwrl_mcu_model #(
    parameter int unsigned PERIOD = 20
) (
    input  wire logic clk,
    input  wire logic alive,
    output logic      retrigger = 1'b0
);
    int unsigned cnt_q = 0;
    // Kicks well inside each timeout window while software is alive
    always_ff @(posedge clk) begin
        cnt_q     <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
        retrigger <= alive && (cnt_q == 0);
    end
endmodule

// [tb/test_board_watchdog_reset_logic.sv]
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
    $display("mismatch %0t got %0h expected %0h", $time, (a), (b)); end end
module test_board_watchdog_reset_logic;
    import bwrl_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, alive = 1'b0, link = 1'b1, pgood = 1'b1, button = 1'b0;
    logic        retrigger, sys_reset_n, exp_reset_n, lamp;
    logic [15:0] boot_vector;
    int          n_mismatch = 0, checks_done = 0, n, n_lamp;
    // ****************************************
    // Clock and instances
    // ****************************************
    always #20 clk = ~clk;
    // Short counts keep the run small: 40 cycles timeout, 20 cycles hold
    bwrl_watchdog #(.TICK_CYCLES(4), .TIMEOUT_T(10), .HOLD_T(5)) i_bwrl_watchdog (
        .clk(clk), .rst(rst), .retrigger(retrigger), .watchdog_link_setting(link),
        .power_good(pgood), .manual_reset_contact(button), .sys_reset_n(sys_reset_n),
        .expansion_bus_connector_reset_n(exp_reset_n), .watchdog_indicator_lamp(lamp),
        .boot_vector(boot_vector));
    bwrl_mcu_model #(.PERIOD(20)) i_bwrl_mcu_model (.clk(clk), .alive(alive), .retrigger(retrigger));
    // ****************************************
    // Tests
    // ****************************************
    task automatic cyc(int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic t_timeout;
        n = 0;
        while (sys_reset_n !== 1'b0 && n < 60) begin cyc(1); n++; end
        `CHK(n >= 36 && n <= 46, 1'b1)
        `CHK(exp_reset_n, 1'b0)
        `CHK(lamp, 1'b1)
        `CHK(boot_vector, BOOT_ADDR)
        n = 0;
        while (sys_reset_n === 1'b0 && n < 40) begin cyc(1); n++; end
        `CHK(n >= 16 && n <= 24, 1'b1)
        `CHK(lamp, 1'b0)
        $display("test timeout done");
    endtask
    task automatic t_retrig;
        @(posedge clk); alive <= 1'b1;
        n = 0;
        repeat (150) begin cyc(1); if (sys_reset_n !== 1'b1) n++; end
        `CHK(n, 0)
        $display("test retrigger done");
    endtask
    task automatic t_link_off;
        @(posedge clk); alive <= 1'b0; link <= 1'b0;
        n = 0;
        n_lamp = 0;
        repeat (70) begin cyc(1); if (sys_reset_n !== 1'b1) n++; if (lamp === 1'b1) n_lamp++; end
        `CHK(n, 0)
        `CHK(n_lamp >= 16 && n_lamp <= 24, 1'b1)
        $display("test link off done");
    endtask
    task automatic t_sources;
        // Power fail first, then the pushbutton, each from a quiet start
        for (int i = 0; i < 2; i++) begin
            @(posedge clk); pgood <= (i != 0); button <= (i == 1);
            cyc(2);
            `CHK(sys_reset_n, 1'b0)
            `CHK(exp_reset_n, 1'b0)
            @(posedge clk); pgood <= 1'b1; button <= 1'b0;
            cyc(2);
            `CHK(sys_reset_n, 1'b1)
        end
        $display("test sources done");
    endtask
    task automatic t_mid_reset;
        // A reset during a watchdog hold must restart the full watch interval
        @(posedge clk);
        link <= 1'b1;
        n = 0;
        while (sys_reset_n !== 1'b0 && n < 80) begin cyc(1); n++; end
        `CHK(sys_reset_n, 1'b0)
        `CHK(lamp, 1'b1)
        @(posedge clk);
        rst <= 1'b1;
        cyc(2);
        `CHK(sys_reset_n, 1'b0)
        `CHK(lamp, 1'b0)
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        cyc(2);
        `CHK(sys_reset_n, 1'b1)
        $display("test mid-run reset done");
        t_timeout();
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        cyc(1);
        `CHK(sys_reset_n, 1'b0)
        `CHK(lamp, 1'b0)
        @(posedge clk);
        rst <= 1'b0;
        cyc(2);
        t_timeout();
        t_retrig();
        t_link_off();
        t_sources();
        t_mid_reset();
        end_sim();
    end
    // Whole sequence needs about 400 cycles, well under the 2000 allowed here
    initial begin
        #(40 * 2000);
        n_mismatch++;
        end_sim();
    end
endmodule
